// file: logic/osy_map.svh
// register offsets, field positions, write masks and reset values of the output synthesizer bank
`ifndef OSY_MAP_SVH
`define OSY_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OSY_ADDR_W          10
`define OSY_ADDR_BASE       10'h0f0
`define OSY_ADDR_CP         10'h0f0
`define OSY_ADDR_FB         10'h0f1
`define OSY_ADDR_CTRL       10'h0f2
`define OSY_ADDR_VCO        10'h0f3
`define OSY_ADDR_DIV        10'h0f4
`define OSY_NUM_REGS        5
`define OSY_IDX_CP          3'h0
`define OSY_IDX_FB          3'h1
`define OSY_IDX_CTRL        3'h2
`define OSY_IDX_VCO         3'h3
`define OSY_IDX_DIV         3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define OSY_FB_FINE_HI      7
`define OSY_FB_FINE_LO      6
`define OSY_FB_COARSE_HI    5
`define OSY_FB_COARSE_LO    0
`define OSY_CTRL_LDPD       7
`define OSY_CTRL_DBL        5
`define OSY_CTRL_ABLMAN     4
`define OSY_CTRL_ABL_HI     3
`define OSY_CTRL_ABL_LO     2
`define OSY_CTRL_CPM_HI     1
`define OSY_CTRL_CPM_LO     0
`define OSY_VCO_FORCEREL    4
`define OSY_VCO_REFVALID    3
`define OSY_VCO_MIDSCALE    2
`define OSY_VCO_CAL         1
`define OSY_DIV_SEC_PD      6
`define OSY_DIV_SEC_HI      5
`define OSY_DIV_SEC_LO      4
`define OSY_DIV_PRI_PD      2
`define OSY_DIV_PRI_HI      1
`define OSY_DIV_PRI_LO      0

// ----------------------------------------
// writable bits (reserved positions stay zero) and reset values
// ----------------------------------------
`define OSY_MASK_CP         8'hff
`define OSY_MASK_FB         8'hff
`define OSY_MASK_CTRL       8'hbf
`define OSY_MASK_VCO        8'h1e
`define OSY_MASK_DIV        8'h77
`define OSY_RST_CP          8'h80
`define OSY_RST_FB          8'h07
`define OSY_RST_CTRL        8'h03
`define OSY_RST_VCO         8'h00
`define OSY_RST_DIV         8'h00
`define OSY_CPM_NORMAL      2'h3
`define OSY_ABL_MIN         2'h0

`endif

// file: logic/osy_pkg.sv
// types shared by the output synthesizer register bank
package osy_pkg;

	// register access request from the serial control port core
	typedef struct packed {
		logic       wr;    // write strobe, one cycle
		logic       rd;    // read strobe, one cycle
		logic [9:0] addr;  // register address
		logic [7:0] wdata; // write data
	} osy_req_t;

	// decoded configuration driven to the analog loop
	typedef struct packed {
		logic [7:0] cp_current;   // charge pump magnitude
		logic [1:0] cp_mode;      // charge pump mode
		logic [1:0] fb_fine;      // fine feedback count
		logic [5:0] fb_coarse;    // coarse feedback count
		logic [7:0] fb_ratio;     // 4*coarse + fine
		logic       fb_illegal;   // counter pair not allowed
		logic       lockdet_pd;   // lock detector powered down
		logic       ref_double;   // reference doubler on
		logic       abl_manual;   // antibacklash width programmed
		logic [1:0] abl_width;    // effective antibacklash width
		logic       ref_valid;    // reference qualified
		logic       vco_midscale; // control voltage forced mid
		logic       vco_cal;      // calibration request level
		logic       sync_hold;    // distribution held in sync
		logic       pri_pd;       // primary post-divider down
		logic [2:0] pri_div;      // primary divide value
		logic       sec_pd;       // secondary post-divider down
		logic [2:0] sec_div;      // secondary divide value
	} osy_cfg_t;

	// distribution sync state, one-hot
	typedef enum logic [1:0] {
		OSY_SYNC_HOLD = 2'b01,
		OSY_SYNC_FREE = 2'b10
	} osy_sync_t;

endpackage

// file: logic/osy_regs.sv
// output synthesizer configuration register bank with sync release control
`timescale 1ns/100ps
`include "osy_map.svh"

module osy_regs
	import osy_pkg::*;
(
	input  wire logic       clk,          // 10 MHz system clock
	input  wire logic       nrst,         // async reset, active low
	input  wire osy_req_t   req,          // register access request
	input  wire logic       synth_locked, // lock detector result
	input  wire logic       osc_valid,    // input cleanup loop oscillator valid
	output      logic [7:0] rdata,        // read data, one cycle after rd
	output      osy_cfg_t   cfg           // decoded configuration
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------

	// post-divider field decode, shared by both dividers
	function automatic logic [2:0] div_decode(input logic [1:0] f);
		case (f)
			2'h1:    div_decode = 3'h4;
			2'h2:    div_decode = 3'h5;
			default: div_decode = 3'h3;
		endcase
	endfunction

	// address to register index; index OSY_NUM_REGS means unmapped
	function automatic logic [2:0] addr_index(input logic [9:0] a);
		logic [9:0] off;
		off = a - `OSY_ADDR_BASE;
		if (a >= `OSY_ADDR_BASE && off < 10'(`OSY_NUM_REGS)) begin
			addr_index = off[2:0];
		end else begin
			addr_index = 3'(`OSY_NUM_REGS);
		end
	endfunction

	// feedback pair check: small coarse counts limit the fine count
	function automatic logic fb_bad(input logic [5:0] b, input logic [1:0] a);
		if (b < 6'h3) begin
			fb_bad = 1'b1;
		end else if (b == 6'h3) begin
			fb_bad = (a != 2'h0);
		end else if (b == 6'h4) begin
			fb_bad = (a > 2'h1);
		end else if (b <= 6'h6) begin
			fb_bad = (a > 2'h2);
		end else begin
			fb_bad = 1'b0;
		end
	endfunction

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] regs_reg  [`OSY_NUM_REGS]; // register file
	logic [7:0] regs_next [`OSY_NUM_REGS]; // next register values
	logic [7:0] mask_c    [`OSY_NUM_REGS]; // writable bits per register
	// reset values are constants, so the asynchronous reset branch reads no logic
	localparam logic [7:0] rst_c [`OSY_NUM_REGS] = '{`OSY_RST_CP, `OSY_RST_FB, `OSY_RST_CTRL, `OSY_RST_VCO, `OSY_RST_DIV};
	logic [7:0] rdata_next;                // next read data
	logic [2:0] idx;                       // decoded index

	assign mask_c = '{`OSY_MASK_CP, `OSY_MASK_FB, `OSY_MASK_CTRL, `OSY_MASK_VCO, `OSY_MASK_DIV};
	assign idx    = addr_index(req.addr);

	// write decode; reserved bits are masked so they always read zero
	always_comb begin
		for (int i = 0; i < `OSY_NUM_REGS; i++) begin
			regs_next[i] = regs_reg[i];
			if (req.wr && idx == 3'(i)) begin
				regs_next[i] = req.wdata & mask_c[i];
			end
		end
		rdata_next = rdata;
		if (req.rd) begin
			// unmapped addresses answer zero
			rdata_next = (idx < 3'(`OSY_NUM_REGS)) ? regs_reg[idx] : 8'h00;
		end
	end

	// one flop per register word, reset to its documented default
	genvar g;
	generate
		for (g = 0; g < `OSY_NUM_REGS; g++) begin : g_reg
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					regs_reg[g] <= rst_c[g];
				end else begin
					regs_reg[g] <= regs_next[g];
				end
			end
		end
	endgenerate

	// read data register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdata_next;
		end
	end

	// ----------------------------------------
	// distribution sync control
	// ----------------------------------------
	osy_sync_t sync_reg;  // current sync state
	osy_sync_t sync_next; // next sync state
	logic      lock_ok;   // usable lock indication
	logic      force_rel; // software release override

	// a powered-down lock detector reports nothing, so it cannot release
	assign lock_ok   = synth_locked && !regs_next[`OSY_IDX_CTRL][`OSY_CTRL_LDPD];
	assign force_rel = regs_next[`OSY_IDX_VCO][`OSY_VCO_FORCEREL];

	// once released on lock the outputs stay free; a later unlock does
	// not re-sync them, which would glitch every channel
	always_comb begin
		case (sync_reg)
			OSY_SYNC_HOLD: begin
				sync_next = lock_ok ? OSY_SYNC_FREE : OSY_SYNC_HOLD;
			end
			OSY_SYNC_FREE: begin
				sync_next = OSY_SYNC_FREE;
			end
			default: begin
				sync_next = OSY_SYNC_HOLD;
			end
		endcase
	end

	// sync state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_reg <= OSY_SYNC_HOLD;
		end else begin
			sync_reg <= sync_next;
		end
	end

	// ----------------------------------------
	// decoded outputs, registered with the register file
	// ----------------------------------------
	osy_cfg_t cfg_next; // next decoded configuration

	// decode from the next register values so outputs change on the write edge
	always_comb begin
		logic [7:0] cp;
		logic [7:0] fb;
		logic [7:0] ct;
		logic [7:0] vc;
		logic [7:0] dv;
		cp = regs_next[`OSY_IDX_CP];
		fb = regs_next[`OSY_IDX_FB];
		ct = regs_next[`OSY_IDX_CTRL];
		vc = regs_next[`OSY_IDX_VCO];
		dv = regs_next[`OSY_IDX_DIV];
		cfg_next            = '0;
		cfg_next.cp_current = cp;
		cfg_next.fb_fine    = fb[`OSY_FB_FINE_HI:`OSY_FB_FINE_LO];
		cfg_next.fb_coarse  = fb[`OSY_FB_COARSE_HI:`OSY_FB_COARSE_LO];
		cfg_next.fb_ratio   = {fb[`OSY_FB_COARSE_HI:`OSY_FB_COARSE_LO], 2'h0}
			+ {6'h00, fb[`OSY_FB_FINE_HI:`OSY_FB_FINE_LO]};
		// flag pairs software should not program
		cfg_next.fb_illegal = fb_bad(cfg_next.fb_coarse, cfg_next.fb_fine);
		cfg_next.lockdet_pd = ct[`OSY_CTRL_LDPD];
		cfg_next.ref_double = ct[`OSY_CTRL_DBL];
		cfg_next.abl_manual = ct[`OSY_CTRL_ABLMAN];
		// width field only counts in programmed mode
		cfg_next.abl_width  = ct[`OSY_CTRL_ABLMAN] ? ct[`OSY_CTRL_ABL_HI:`OSY_CTRL_ABL_LO]
			: `OSY_ABL_MIN;
		cfg_next.cp_mode    = ct[`OSY_CTRL_CPM_HI:`OSY_CTRL_CPM_LO];
		cfg_next.ref_valid  = osc_valid || vc[`OSY_VCO_REFVALID];
		cfg_next.vco_midscale = vc[`OSY_VCO_MIDSCALE];
		cfg_next.vco_cal    = vc[`OSY_VCO_CAL];
		cfg_next.sync_hold  = (sync_next == OSY_SYNC_HOLD) && !force_rel;
		cfg_next.pri_pd     = dv[`OSY_DIV_PRI_PD];
		cfg_next.sec_pd     = dv[`OSY_DIV_SEC_PD];
		cfg_next.pri_div    = div_decode(dv[`OSY_DIV_PRI_HI:`OSY_DIV_PRI_LO]);
		cfg_next.sec_div    = div_decode(dv[`OSY_DIV_SEC_HI:`OSY_DIV_SEC_LO]);
	end

	// configuration output register; reset matches the register defaults
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg            <= '0;
			cfg.cp_current <= `OSY_RST_CP;
			cfg.cp_mode    <= `OSY_CPM_NORMAL;
			cfg.fb_coarse  <= 6'h07;
			cfg.fb_ratio   <= 8'h1c;
			cfg.sync_hold  <= 1'b1;
			cfg.pri_div    <= 3'h3;
			cfg.sec_div    <= 3'h3;
		end else begin
			cfg <= cfg_next;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// write to a given register
	sequence s_wr(logic [9:0] a);
		req.wr && req.addr == a;
	endsequence

	// read of a given register
	sequence s_rd(logic [9:0] a);
		req.rd && req.addr == a;
	endsequence

	// locked with the detector running while still held
	sequence s_lock_seen;
		sync_reg == OSY_SYNC_HOLD && synth_locked && !cfg.lockdet_pd && !(req.wr && req.addr == `OSY_ADDR_CTRL);
	endsequence

	a_cp_current: assert property (s_wr(`OSY_ADDR_CP) |=> cfg.cp_current == $past(req.wdata))
		else $error("charge pump current not taken from write");
	a_fb_ratio: assert property (cfg.fb_ratio == {cfg.fb_coarse, 2'h0} + {6'h00, cfg.fb_fine})
		else $error("feedback ratio mismatch");
	// coarse 3 with fine 1 is outside the allowed table
	a_fb_legal: assert property (s_wr(`OSY_ADDR_FB) ##0 req.wdata == 8'h43 |=> cfg.fb_illegal)
		else $error("illegal counter pair not flagged");
	// coarse 7 with fine 0 is the smallest pair with every fine count allowed
	a_fb_legal_ok: assert property (s_wr(`OSY_ADDR_FB) ##0 req.wdata == 8'h07 |=> !cfg.fb_illegal)
		else $error("legal counter pair flagged");
	a_ldpd_write: assert property (s_wr(`OSY_ADDR_CTRL) |=> cfg.lockdet_pd == $past(req.wdata[7])
		&& cfg.ref_double == $past(req.wdata[5]))
		else $error("lock detector or doubler bit not applied");
	a_ctrl_reserved: assert property (regs_reg[`OSY_IDX_CTRL][6] == 1'b0)
		else $error("reserved control bit set");
	a_abl_auto: assert property (!cfg.abl_manual |-> cfg.abl_width == `OSY_ABL_MIN)
		else $error("antibacklash width used in automatic mode");
	// programmed antibacklash mode follows the written width field
	a_abl_manual: assert property (s_wr(`OSY_ADDR_CTRL) ##0 req.wdata[4] |=>
		cfg.abl_manual && cfg.abl_width == $past(req.wdata[3:2]))
		else $error("programmed antibacklash width not applied");
	a_cp_mode: assert property (s_wr(`OSY_ADDR_CTRL) |=> cfg.cp_mode == $past(req.wdata[1:0]))
		else $error("pump mode not applied");
	a_sync_release: assert property (s_lock_seen |=> !cfg.sync_hold ##1 !cfg.sync_hold)
		else $error("sync not released after lock");
	// a powered-down detector never releases the hold on its own
	a_sync_pd_hold: assert property (sync_reg == OSY_SYNC_HOLD && cfg.lockdet_pd
		&& !(req.wr && req.addr == `OSY_ADDR_CTRL) |=> sync_reg == OSY_SYNC_HOLD)
		else $error("powered-down detector released the hold");
	// a release on lock lasts until reset, whatever the detector says later
	a_sync_latched: assert property (sync_reg == OSY_SYNC_FREE |=> sync_reg == OSY_SYNC_FREE)
		else $error("released distribution fell back into hold");
	// the override bit frees the outputs in the cycle after its write
	a_sync_force: assert property (s_wr(`OSY_ADDR_VCO) ##0 req.wdata[4] |=> !cfg.sync_hold)
		else $error("forced release ignored");
	a_ref_valid: assert property (cfg.ref_valid |-> $past(osc_valid) || regs_reg[`OSY_IDX_VCO][3])
		else $error("reference valid without cause");
	// oscillator control fields take the written bits
	a_vco_fields: assert property (s_wr(`OSY_ADDR_VCO) |=>
		cfg.vco_midscale == $past(req.wdata[2]) && cfg.vco_cal == $past(req.wdata[1]))
		else $error("oscillator control bits not applied");
	// hardware never clears the calibration level by itself
	a_cal_hold: assert property (cfg.vco_cal && !(req.wr && req.addr == `OSY_ADDR_VCO) |=> cfg.vco_cal)
		else $error("calibration bit cleared by hardware");
	// each post-divider power-down follows its own bit
	a_div_pd: assert property (s_wr(`OSY_ADDR_DIV) |=>
		cfg.pri_pd == $past(req.wdata[2]) && cfg.sec_pd == $past(req.wdata[6]))
		else $error("post-divider power-down not applied");
	// divide values written out per code; both unused codes mean three
	a_pri_div: assert property (s_wr(`OSY_ADDR_DIV) |=>
		cfg.pri_div == ($past(req.wdata[1:0]) == 2'h1 ? 3'h4 : $past(req.wdata[1:0]) == 2'h2 ? 3'h5 : 3'h3))
		else $error("primary divide value wrong");
	a_sec_div: assert property (s_wr(`OSY_ADDR_DIV) |=>
		cfg.sec_div == ($past(req.wdata[5:4]) == 2'h1 ? 3'h4 : $past(req.wdata[5:4]) == 2'h2 ? 3'h5 : 3'h3))
		else $error("secondary divide value wrong");
	a_div_decode: assert property (cfg.pri_div >= 3'h3 && cfg.pri_div <= 3'h5
		&& cfg.sec_div >= 3'h3 && cfg.sec_div <= 3'h5)
		else $error("post-divider value out of range");
	// a plain read returns the stored magnitude one cycle later
	a_rd_cp: assert property (s_rd(`OSY_ADDR_CP) ##0 !req.wr |=> rdata == cfg.cp_current)
		else $error("read data differs from stored magnitude");
	// places outside the bank answer zero
	a_rd_unmapped: assert property (req.rd && (req.addr < `OSY_ADDR_BASE || req.addr > `OSY_ADDR_DIV) |=>
		rdata == 8'h00)
		else $error("unmapped read not zero");

endmodule

// file: verification/tb_top.sv
// self-checking testbench for the output synthesizer register bank
`timescale 1ns/100ps
`include "osy_map.svh"

module tb_top
	import osy_pkg::*;
;
	// ----------------------------------------
	// signals and reference model state
	// ----------------------------------------
	logic       clk;          // 10 MHz bench clock
	logic       nrst;         // async reset, active low
	osy_req_t   req;          // register request
	logic       synth_locked; // lock indication driven by the bench
	logic       osc_valid;    // oscillator valid driven by the bench
	logic [7:0] rdata;        // read data from the bank
	osy_cfg_t   cfg;          // decoded configuration
	logic [7:0] sh [5];       // shadow of the five registers
	logic       rel;          // model: released on lock
	logic       lk;           // lock level for the next request
	logic       ov;           // oscillator valid for the next request
	logic       pend;         // a read result is due this edge
	logic [7:0] exp_r;        // oldest expected read value
	osy_cfg_t   exp_c;        // oldest expected configuration
	logic [7:0] q_rd [$];     // expected read values, oldest first
	osy_cfg_t   q_cfg [$];    // expected configurations, oldest first
	int         n_errors;     // mismatches seen
	int         n_compared;   // comparisons made
	localparam logic [7:0] MSK [5] = '{`OSY_MASK_CP, `OSY_MASK_FB, `OSY_MASK_CTRL, `OSY_MASK_VCO, `OSY_MASK_DIV};
	localparam logic [7:0] RST [5] = '{`OSY_RST_CP, `OSY_RST_FB, `OSY_RST_CTRL, `OSY_RST_VCO, `OSY_RST_DIV};

	osy_regs DUT (
		.clk          (clk),
		.nrst         (nrst),
		.req          (req),
		.synth_locked (synth_locked),
		.osc_valid    (osc_valid),
		.rdata        (rdata),
		.cfg          (cfg)
	);

	// free-running clock, 100 ns period
	always #50 clk = ~clk;

	// ----------------------------------------
	// expectation helpers
	// ----------------------------------------
	// post-divider decode: the two unused codes both mean three
	function automatic logic [2:0] dv(input logic [1:0] s);
		return (s == 2'h1) ? 3'h4 : (s == 2'h2) ? 3'h5 : 3'h3;
	endfunction

	// configuration the bank should show after the current edge
	function automatic osy_cfg_t ecfg();
		osy_cfg_t   c;
		logic [5:0] b;
		logic [1:0] a;
		b = sh[1][5:0];
		a = sh[1][7:6];
		c.cp_current   = sh[0];
		c.cp_mode      = sh[2][1:0];
		c.fb_fine      = a;
		c.fb_coarse    = b;
		c.fb_ratio     = {b, 2'h0} + {6'h00, a};
		c.fb_illegal   = (b < 6'h03) || (b == 6'h03 && a != 2'h0) || (b == 6'h04 && a > 2'h1) || (b < 6'h07 && a == 2'h3);
		c.lockdet_pd   = sh[2][7];
		c.ref_double   = sh[2][5];
		c.abl_manual   = sh[2][4];
		c.abl_width    = sh[2][4] ? sh[2][3:2] : 2'h0; // width ignored in automatic mode
		c.ref_valid    = ov | sh[3][3];
		c.vco_midscale = sh[3][2];
		c.vco_cal      = sh[3][1];
		c.sync_hold    = !(rel || sh[3][4]);
		c.pri_pd       = sh[4][2];
		c.pri_div      = dv(sh[4][1:0]);
		c.sec_pd       = sh[4][6];
		c.sec_div      = dv(sh[4][5:4]);
		return c;
	endfunction

	task automatic err(input string m);
		n_errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	// ----------------------------------------
	// driver: one request per edge, notes the expected result
	// ----------------------------------------
	task automatic acc(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
		logic       ok;
		logic [2:0] i;
		logic [7:0] old;
		ok  = (a >= 10'h0f0) && (a <= 10'h0f4);
		i   = 3'(a - 10'h0f0);
		old = ok ? sh[i] : 8'h00; // a read in the write cycle returns the old value
		@(posedge clk);
		req          <= '{wr: w, rd: r, addr: a, wdata: d};
		synth_locked <= lk;
		osc_valid    <= ov;
		if (w && ok) sh[i] = d & MSK[i];
		if (lk && !sh[2][7]) rel = 1'b1; // release latches until reset
		if (r) begin
			q_rd.push_back(old);
			q_cfg.push_back(ecfg());
		end
	endtask

	// idle first so no read result is lost inside the reset
	task automatic do_reset();
		lk = 1'b0;
		acc(1'b0, 1'b0, 10'h000, 8'h00);
		acc(1'b0, 1'b0, 10'h000, 8'h00);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		foreach (sh[k]) sh[k] = RST[k];
		rel = 1'b0;
	endtask

	task automatic give_verdict();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// monitor: compares each read result with the oldest note
	// ----------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			pend = 1'b0;
		end else begin
			if (pend) begin
				if (q_rd.size() == 0) begin
					err("result without expectation");
				end else begin
					exp_r = q_rd.pop_front();
					exp_c = q_cfg.pop_front();
					n_compared += 2;
					if (rdata !== exp_r) err($sformatf("rdata %h exp %h", rdata, exp_r));
					if (cfg !== exp_c) err($sformatf("cfg %h exp %h", cfg, exp_c));
				end
			end
			pend = req.rd;
		end
	end

	// watchdog: the sequence needs about 1700 cycles
	initial begin
		repeat (6000) @(posedge clk);
		err("timeout");
		give_verdict();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0; nrst = 1'b0; req = '0; synth_locked = 1'b0; osc_valid = 1'b0;
		lk = 1'b0; ov = 1'b0; rel = 1'b0; pend = 1'b0; n_errors = 0; n_compared = 0;
		foreach (sh[k]) sh[k] = RST[k];
		void'($urandom(6));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		// reset values, plus one unmapped place
		for (int k = 0; k < 6; k++) acc(1'b0, 1'b1, 10'h0f0 + 10'(k), 8'h00);
		// back-to-back writes, each read returning the previous value
		for (int k = 0; k < 8; k++) acc(1'b1, 1'b1, 10'h0f0, 8'($urandom()));
		acc(1'b0, 1'b1, 10'h0f0, 8'h00);
		// counter pairs across the legality boundaries and the largest ratio
		for (int b = 0; b < 10; b++)
			for (int a = 0; a < 4; a++) begin
				acc(1'b1, 1'b0, 10'h0f1, {2'(a), 6'(b)});
				acc(1'b0, 1'b1, 10'h0f1, 8'h00);
			end
		acc(1'b1, 1'b1, 10'h0f1, 8'hff);
		// every value of the control, oscillator and divider registers
		for (int r = 2; r < 5; r++)
			for (int k = 0; k < 256; k++) begin
				ov = 1'($urandom());
				acc(1'b1, 1'b0, 10'h0f0 + 10'(r), 8'(k));
				acc(1'b0, 1'b1, 10'h0f0 + 10'(r), 8'h00);
			end
		// calibration level stays until software clears it
		acc(1'b1, 1'b0, 10'h0f3, 8'h02);
		repeat (5) acc(1'b0, 1'b1, 10'h0f3, 8'h00);
		acc(1'b1, 1'b1, 10'h0f3, 8'h00);
		acc(1'b0, 1'b1, 10'h0f3, 8'h00);
		// lock with the detector powered down must not release
		lk = 1'b1;
		acc(1'b1, 1'b0, 10'h0f2, 8'h83);
		repeat (3) acc(1'b0, 1'b1, 10'h0f2, 8'h00);
		acc(1'b1, 1'b1, 10'h0f3, 8'h10);
		acc(1'b1, 1'b1, 10'h0f3, 8'h00);
		acc(1'b0, 1'b1, 10'h0f3, 8'h00);
		// detector back on: release, then a lost lock is ignored
		acc(1'b1, 1'b0, 10'h0f2, 8'h03);
		lk = 1'b0;
		acc(1'b0, 1'b1, 10'h0f2, 8'h00);
		acc(1'b0, 1'b1, 10'h0f2, 8'h00);
		// unmapped places ignore writes and read zero
		acc(1'b1, 1'b1, 10'h0f5, 8'haa);
		acc(1'b1, 1'b1, 10'h0ef, 8'h55);
		acc(1'b0, 1'b1, 10'h0f5, 8'h00);
		acc(1'b0, 1'b1, 10'h0ef, 8'h00);
		// second reset in mid-run brings the hold back
		do_reset();
		acc(1'b0, 1'b1, 10'h0f3, 8'h00);
		acc(1'b0, 1'b1, 10'h0f4, 8'h00);
		repeat (3) acc(1'b0, 1'b0, 10'h000, 8'h00);
		if (q_rd.size() != 0) err("results missing");
		give_verdict();
	end
endmodule
